/* File: logic/dcr_defines.vh */
`ifndef DCR_DEFINES_VH
`define DCR_DEFINES_VH
// ----------------------------------------
// register location and byte lanes
// ----------------------------------------
`define DCR_ADDR_W 6
`define DCR_ADDR_BYTE3 6'h1D
`define DCR_ADDR_BYTE2 6'h1E
`define DCR_ADDR_BYTE1 6'h1F
`define DCR_ADDR_BYTE0 6'h20
// ----------------------------------------
// field positions
// ----------------------------------------
`define DCR_BIT_CMP_PD 28
`define DCR_BIT_LOCKUP 27
`define DCR_BIT_CDAC_PD 26
`define DCR_BIT_FDAC_PD 25
`define DCR_BIT_DIG_PD 24
`define DCR_BIT_PLL_RANGE 22
`define DCR_BIT_PLL_BYP 21
`define DCR_MULT_HI 20
`define DCR_MULT_LO 16
`define DCR_BIT_CLR_ONE 15
`define DCR_BIT_CLR_HOLD 14
`define DCR_BIT_TRIANGLE 13
`define DCR_MODE_HI 11
`define DCR_MODE_LO 9
// ----------------------------------------
// reset value and constants
// ----------------------------------------
`define DCR_RESET_VALUE 32'h0060_0000
`define DCR_KEEP_MASK 32'h1F7F_7FFF
`define DCR_MODE_SINGLE 3'h0
`define DCR_MODE_FSK 3'h1
`define DCR_MODE_RAMP_FSK 3'h2
`define DCR_MODE_CHIRP 3'h3
`define DCR_MODE_BPSK 3'h4
`define DCR_MULT_MIN 5'h04
`define DCR_MULT_MAX 5'h14
`endif

/* File: logic/dcr_triangle.v */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// triangle sweep direction tracker
// ----------------------------------------
module dcr_triangle (
    input wire clk_i,
    input wire rst_i,
    input wire enable_i,
    input wire at_end_i,
    input wire at_start_i,
    output reg sweep_up_o
);
    // direction flips at each end; restarts upward when disabled
    always @(posedge clk_i) begin
        if (rst_i || !enable_i) begin
            sweep_up_o <= 1'b1;
        end else if (sweep_up_o && at_end_i) begin
            sweep_up_o <= 1'b0;
        end else if (!sweep_up_o && at_start_i) begin
            sweep_up_o <= 1'b1;
        end
    end
endmodule // dcr_triangle
`default_nettype wire

/* File: logic/dcr_control_word.v */
// Notes on behaviour
// - one 32-bit control word at byte addresses 1D to 20 hex, bit 31 MSB
// - bit 28 powers down the comparator
// - bit 27 must be zero; writing one halts until master reset
// - bit 26 powers down the control DAC only
// - bit 25 powers down cosine DAC, control DAC and reference
// - bit 24 stops digital clocks; PLL keeps running
// - bit 22 selects VCO gain range, resets to one
// - bit 21 bypasses PLL, resets to one; reference drives system clock
// - bits 20:16 multiply factor, used only when bypass clear, range 4..20
// - writing one to bit 15 pulses accumulator 1 clear, then self-clears
// - the one-shot clear acts the same in every operating mode
// - bit 14 holds both accumulators at zero while set
// - bit 13 sweeps start to end frequency and back continuously, only while mode field is ramped FSK
// - mode field 11:9 value 2 is ramped FSK; others as listed
`timescale 1ns/100ps
`default_nettype none
`include "dcr_defines.vh"
module dcr_control_word #(
    parameter MULT_W = 5
) (
    input wire clk_i,
    input wire rst_i,
    input wire wr_en_i,
    input wire rd_en_i,
    input wire [`DCR_ADDR_W-1:0] addr_i,
    input wire [7:0] wr_data_i,
    input wire sweep_at_end_i,
    input wire sweep_at_start_i,
    output reg [7:0] rd_data_o,
    output wire hit_o,
    output reg [31:0] control_word_o,
    output wire comparator_pd_o,
    output wire control_dac_pd_o,
    output wire cosine_dac_pd_o,
    output wire reference_pd_o,
    output wire digital_clk_en_o,
    output wire pll_clk_en_o,
    output wire pll_high_range_o,
    output wire pll_bypass_o,
    output wire pll_powered_o,
    output wire [MULT_W-1:0] pll_mult_o,
    output wire pll_mult_valid_o,
    output reg acc1_clear_o,
    output wire acc_hold_clear_o,
    output wire triangle_active_o,
    output wire sweep_up_o,
    output wire [2:0] mode_o,
    output wire ramp_fsk_o,
    output reg halted_o
);
    // ----------------------------------------
    // byte lane decode
    // ----------------------------------------
    function [1:0] lane_of;
        input [`DCR_ADDR_W-1:0] a;
        begin
            case (a)
                `DCR_ADDR_BYTE3: lane_of = 2'h3;
                `DCR_ADDR_BYTE2: lane_of = 2'h2;
                `DCR_ADDR_BYTE1: lane_of = 2'h1;
                default: lane_of = 2'h0;
            endcase
        end
    endfunction

    // one-hot write strobe per byte lane
    function [3:0] lane_hot;
        input [1:0] l;
        begin
            lane_hot = 4'h1 << l;
        end
    endfunction

    // pick one byte of the word for the read port
    function [7:0] byte_of;
        input [31:0] w;
        input [1:0] l;
        begin
            case (l)
                2'h3: byte_of = w[31:24];
                2'h2: byte_of = w[23:16];
                2'h1: byte_of = w[15:8];
                default: byte_of = w[7:0];
            endcase
        end
    endfunction

    // multiplier factors the pll can lock to
    function mult_ok;
        input [MULT_W-1:0] m;
        begin
            mult_ok = (m >= `DCR_MULT_MIN) && (m <= `DCR_MULT_MAX);
        end
    endfunction

    // ----------------------------------------
    // request qualification
    // ----------------------------------------
    wire [1:0] lane;
    wire in_range;
    wire wr_take;
    wire rd_take;
    wire [3:0] lane_wr;
    wire [31:0] keep_mask;
    wire [31:0] byte_in;
    reg [31:0] word_next;
    reg clr_next;
    reg lock_next;
    assign lane = lane_of(addr_i);
    assign in_range = (addr_i >= `DCR_ADDR_BYTE3) &&
                      (addr_i <= `DCR_ADDR_BYTE0);
    // hit is combinational so a host sees a miss at once
    assign hit_o = in_range;
    // a halted part refuses every write until the master reset
    assign wr_take = wr_en_i && in_range && !halted_o;
    assign rd_take = rd_en_i && in_range;
    assign lane_wr = wr_take ? lane_hot(lane) : 4'h0;
    assign keep_mask = `DCR_KEEP_MASK;

    // ----------------------------------------
    // write path
    // ----------------------------------------
    // each lane takes the new byte or keeps the stored one
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lane
            assign byte_in[8*g+7:8*g] = lane_wr[g] ? wr_data_i :
                                        control_word_o[8*g+7:8*g];
        end
    endgenerate

    // the one-shot bit is never stored, so reads show it as zero
    always @* begin
        word_next = byte_in & keep_mask;
        clr_next = lane_wr[1] && byte_in[`DCR_BIT_CLR_ONE];
        lock_next = lane_wr[3] && byte_in[`DCR_BIT_LOCKUP];
    end

    // ----------------------------------------
    // register storage
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            control_word_o <= `DCR_RESET_VALUE;
            acc1_clear_o <= 1'b0;
            halted_o <= 1'b0;
        end else begin
            control_word_o <= word_next;
            acc1_clear_o <= clr_next;
            // lockup is sticky; only the master reset above leaves it
            if (lock_next) begin
                halted_o <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // unmapped reads answer zero rather than a stale byte
    always @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_o <= 8'h00;
        end else if (rd_take) begin
            rd_data_o <= byte_of(control_word_o, lane);
        end else if (rd_en_i) begin
            rd_data_o <= 8'h00;
        end
    end

    // ----------------------------------------
    // power-down controls
    // ----------------------------------------
    assign comparator_pd_o = control_word_o[`DCR_BIT_CMP_PD];
    // full dac power-down forces the control dac down as well
    assign control_dac_pd_o = control_word_o[`DCR_BIT_CDAC_PD] |
                              control_word_o[`DCR_BIT_FDAC_PD];
    assign cosine_dac_pd_o = control_word_o[`DCR_BIT_FDAC_PD];
    assign reference_pd_o = control_word_o[`DCR_BIT_FDAC_PD];
    // a halted part also freezes its digital clocks
    assign digital_clk_en_o = !control_word_o[`DCR_BIT_DIG_PD] &&
                              !halted_o;

    // ----------------------------------------
    // pll controls
    // ----------------------------------------
    assign pll_clk_en_o = !pll_bypass_o;
    assign pll_high_range_o = control_word_o[`DCR_BIT_PLL_RANGE];
    assign pll_bypass_o = control_word_o[`DCR_BIT_PLL_BYP];
    assign pll_powered_o = !control_word_o[`DCR_BIT_PLL_BYP];
    assign pll_mult_o = control_word_o[`DCR_MULT_HI:`DCR_MULT_LO];
    // the factor only means something with the pll in the loop
    assign pll_mult_valid_o = !pll_bypass_o &&
                              mult_ok(pll_mult_o);

    // ----------------------------------------
    // accumulator and sweep controls
    // ----------------------------------------
    assign acc_hold_clear_o = control_word_o[`DCR_BIT_CLR_HOLD];
    assign mode_o = control_word_o[`DCR_MODE_HI:`DCR_MODE_LO];
    assign ramp_fsk_o = (mode_o == `DCR_MODE_RAMP_FSK);
    // sweeping is gated here on the mode field being ramped FSK
    // other mode codes leave the direction tracker idle
    assign triangle_active_o = control_word_o[`DCR_BIT_TRIANGLE] &&
                               ramp_fsk_o;

    // ----------------------------------------
    // triangle sweep direction
    // ----------------------------------------
    dcr_triangle u_triangle (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(triangle_active_o),
        .at_end_i(sweep_at_end_i),
        .at_start_i(sweep_at_start_i),
        .sweep_up_o(sweep_up_o)
    );
endmodule // dcr_control_word
`default_nettype wire

/* File: testbench/dcr_control_word_props.sv */
`timescale 1ns/100ps
`default_nettype none
// -----
// checker
// -----
module dcr_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [5:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [31:0] control_word_o,
    input wire logic acc1_clear_o,
    input wire logic halted_o,
    input wire logic control_dac_pd_o,
    input wire logic digital_clk_en_o,
    input wire logic pll_mult_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic [31:0] w = control_word_o;
    wire logic [4:0] m = w[20:16];
    sequence s_wr(a);
        wr_en_i && !halted_o && addr_i == a;
    endsequence
    sequence s_pulse;
        acc1_clear_o ##1 !acc1_clear_o;
    endsequence
    a_clear_one_shot: assert property (
        s_wr(6'h1F) ##0 wr_data_i[7] |=> s_pulse) else $error("clear");
    a_lockup_sets: assert property (
        s_wr(6'h1D) ##0 wr_data_i[3] |=> halted_o) else $error("halt");
    a_halt_sticky: assert property (
        halted_o |=> halted_o && $stable(w)) else $error("sticky");
    a_reserved_zero: assert property (
        {w[31:29], w[23], w[15]} == 5'h00 && (!w[27] || halted_o))
        else $error("resv");
    a_byte_lane: assert property (
        s_wr(6'h1E) |=> w[23:16] == ($past(wr_data_i) & 8'h7F))
        else $error("lane");
    a_dac_pd: assert property (
        control_dac_pd_o == (w[26] | w[25])) else $error("dac");
    a_digital_pd: assert property (
        digital_clk_en_o == !(w[24] | halted_o)) else $error("dig");
    a_mult_range: assert property (
        pll_mult_valid_o == (!w[21] && m >= 5'h04 && m <= 5'h14))
        else $error("mult");
endmodule // dcr_props
bind dcr_control_word dcr_props i_props (.clk_i(clk_i), .rst_i(rst_i),
    .wr_en_i(wr_en_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .control_word_o(control_word_o), .acc1_clear_o(acc1_clear_o),
    .halted_o(halted_o), .control_dac_pd_o(control_dac_pd_o),
    .digital_clk_en_o(digital_clk_en_o),
    .pll_mult_valid_o(pll_mult_valid_o));
`default_nettype wire

/* File: testbench/dcr_host.sv */
`timescale 1ns/100ps
`default_nettype none
module dcr_host (
    input wire logic clk_i,
    output logic wr_en_o = 1'b0,
    output logic rd_en_o = 1'b0,
    output logic [5:0] addr_o = 6'h00,
    output logic [7:0] data_o = 8'h00
);
    // released data is inverted so a stale byte never looks valid
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        data_o = d;
        wr_en_o = 1'b1;
        @(negedge clk_i);
        wr_en_o = 1'b0;
        data_o = ~d;
    endtask
    task automatic rd(input logic [5:0] a);
        @(negedge clk_i);
        addr_o = a;
        rd_en_o = 1'b1;
        @(negedge clk_i);
        rd_en_o = 1'b0;
    endtask
endmodule // dcr_host
`default_nettype wire

/* File: testbench/test_dcr_control_word.sv */
`timescale 1ns/100ps
`default_nettype none
module test_dcr_control_word;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ae = 1'b0;
    logic as = 1'b0;
    wire logic we, re, cmp, cd, dc, hr, byp, mv, clr, hd, tr, up, rf, ht;
    wire logic hi, cp, rp, pe, pp;
    wire logic [5:0] ad;
    wire logic [7:0] wd, rd;
    wire logic [31:0] cw;
    wire logic [4:0] mu;
    wire logic [2:0] md;
    int n_fail = 0;
    int checks = 0;
    always #2 clk_i = ~clk_i;
    dcr_host i_host (.clk_i(clk_i), .wr_en_o(we), .rd_en_o(re),
        .addr_o(ad), .data_o(wd));
    dcr_control_word i_dut (.clk_i(clk_i), .rst_i(rst_i), .wr_en_i(we),
        .rd_en_i(re), .addr_i(ad), .wr_data_i(wd), .sweep_at_end_i(ae),
        .sweep_at_start_i(as), .rd_data_o(rd), .hit_o(hi),
        .control_word_o(cw), .comparator_pd_o(cmp),
        .control_dac_pd_o(cd), .cosine_dac_pd_o(cp), .reference_pd_o(rp),
        .digital_clk_en_o(dc), .pll_clk_en_o(pe), .pll_high_range_o(hr),
        .pll_bypass_o(byp), .pll_powered_o(pp), .pll_mult_o(mu),
        .pll_mult_valid_o(mv), .acc1_clear_o(clr), .acc_hold_clear_o(hd),
        .triangle_active_o(tr), .sweep_up_o(up), .mode_o(md),
        .ramp_fsk_o(rf), .halted_o(ht));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rdb(input logic [5:0] a, input logic [7:0] e);
        i_host.rd(a);
        chk(32'(rd), 32'(e));
    endtask
    task automatic report_and_stop;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic t_regs;
        logic [7:0] v [5] = '{8'h03, 8'h04, 8'h14, 8'h15, 8'h34};
        rdb(6'h1E, 8'h60);
        i_host.wr(6'h1D, 8'h17);
        rdb(6'h1D, 8'h17);
        for (int i = 0; i < 5; i++) begin
            i_host.wr(6'h1E, v[i]);
            chk(32'({mv, byp, mu}), 32'({i == 1 || i == 2, v[i][5:0]}));
            chk(32'({pe, pp}), 32'({2{!v[i][5]}}));
        end
        chk(32'({cmp, cd, dc, hr}), 32'hC);
        chk(32'({cp, rp}), 32'h3);
        i_host.wr(6'h1E, 8'hFF);
        rdb(6'h1E, 8'h7F);
        chk(32'(hi), 32'h1);
        i_host.wr(6'h21, 8'hFF);
        chk(32'(hi), 32'h0);
        chk(cw, 32'h177F0000);
        $display("t_regs done");
    endtask
    task automatic t_clear;
        for (int m = 0; m < 5; m++) begin
            i_host.wr(6'h1F, 8'h80 | 8'(m << 1));
            chk(32'(clr), 32'h1);
            @(negedge clk_i);
            chk(32'({clr, rf, md}), 32'({1'b0, m == 2, 3'(m)}));
        end
        rdb(6'h1F, 8'h08);
        i_host.wr(6'h1F, 8'h64);
        chk(32'({hd, tr, up}), 32'h7);
        ae = 1'b1;
        repeat (3) @(negedge clk_i);
        chk(32'(up), 32'h0);
        ae = 1'b0;
        as = 1'b1;
        repeat (3) @(negedge clk_i);
        chk(32'(up), 32'h1);
        as = 1'b0;
        i_host.wr(6'h1F, 8'h20);
        chk(32'(tr), 32'h0);
        $display("t_clear done");
    endtask
    task automatic t_lock;
        i_host.wr(6'h1D, 8'h08);
        chk(32'({ht, dc}), 32'h2);
        i_host.wr(6'h1E, 8'h00);
        rdb(6'h1E, 8'h7F);
        rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        chk(cw, 32'h00600000);
        $display("t_lock done");
    endtask
    initial begin
        repeat (20) @(negedge clk_i);
        rst_i = 1'b0;
        t_regs();
        t_clear();
        t_lock();
        report_and_stop();
    end
    // the tests need about 80 cycles; allow far more
    initial begin
        #(4000 * 4);
        n_fail++;
        report_and_stop();
    end
endmodule // test_dcr_control_word
`default_nettype wire
